// >>> hdl/ees_slave.sv
// Purpose: Write path of a two-wire serial slave for a byte memory
// Assumes: Master drives the bus clock; pins arrive asynchronously
// Notes: Reads are handed off after the select acknowledge
`timescale 1ns/1ps
module ees_slave #(
    parameter int unsigned WR_CYCLES = ees_pkg::TW_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Serial bus pins
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    // Straps
    input wire logic i_chip_addr_pin_lo,
    input wire logic i_chip_addr_pin_hi,
    input wire logic i_write_protect_in,
    input wire logic i_id_locked_nv,
    // Array write port
    output logic o_wr_valid,
    output ees_pkg::ees_wr_s o_wr_entry,
    input wire logic i_wr_ready,
    // Status
    output logic o_busy,
    output logic o_id_locked,
    output logic [16:0] o_addr_cnt
);

    localparam logic [19:0] TW_LAST = 20'(WR_CYCLES - 1);

    // Select byte decode, shared by acknowledge and next-state logic
    function automatic logic sel_ok(input logic [7:0] b,
                                    input logic [1:0] chip);
        logic type_ok;
        type_ok = (b[7:4] == ees_pkg::TYPE_MEM) ||
                  (b[7:4] == ees_pkg::TYPE_ID);
        sel_ok = type_ok && (b[3:2] == chip);
    endfunction

    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic scl_d_ff;
    logic sda_d_ff;
    ees_pkg::ees_state_e state_ff;
    ees_pkg::ees_state_e after_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic in_ack_ff;
    logic ack_dec_ff;
    logic data_acked_ff;
    logic top_bit_ff;
    logic id_sel_ff;
    logic [7:0] addr_hi_ff;
    logic [7:0] addr_lo_ff;
    logic [7:0] last_lo_ff;
    logic [1:0] nbytes_ff;
    logic lock_ok_ff;
    logic lock_pend_ff;
    logic lock_ff;
    logic busy_ff;
    logic [19:0] tw_cnt_ff;
    logic [6:0] grp_ff;
    logic [255:0] mask_ff;
    logic [7:0] page_mem [0:ees_pkg::PAGE_BYTES-1];
    logic [16:0] addr_cnt_ff;
    logic sda_oe_n_ff;
    logic sda_out_ff;
    ees_pkg::ees_wr_s head_ff;
    ees_pkg::ees_wr_s tail_ff;
    logic head_vld_ff;
    logic tail_vld_ff;

    // Synchronised pins: scl, sda, chip lo, chip hi, write protect
    wire scl_s = sync2_ff[0];
    wire sda_s = sync2_ff[1];
    wire [1:0] chip_s = sync2_ff[3:2];
    // only a driven high protects; the pad pull-down resolves floats
    wire wp_s = sync2_ff[4];

    // Bus events; starts and stops are ignored while busy
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s & ~busy_ff;
    wire stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s & ~busy_ff;
    wire active = (state_ff != ees_pkg::ST_IDLE);
    wire byte_done = scl_rise & active & (bit_cnt_ff == ees_pkg::BIT_LAST);
    wire ack_open = scl_fall & (bit_cnt_ff == ees_pkg::BIT_ACK) & ~in_ack_ff;
    wire ack_close = scl_fall & in_ack_ff;
    wire [7:0] byte_in = {shift_ff[6:0], sda_s};

    // Data byte acceptance and command classification
    wire lock_cmd = id_sel_ff & addr_hi_ff[ees_pkg::LOCK_SEL_BIT];
    wire data_ok = ~wp_s & ~(id_sel_ff & lock_ff);
    wire in_data = (state_ff == ees_pkg::ST_DATA);
    wire store = byte_done & in_data & data_ok & ~lock_cmd;
    wire sel_hit = sel_ok(byte_in, chip_s);
    wire sel_rd = byte_in[ees_pkg::SEL_RW_BIT];
    wire wr_trig = stop_det & in_data & data_acked_ff & ~in_ack_ff;
    wire [8:0] page_hi = id_sel_ff ? 9'h000 : {top_bit_ff, addr_hi_ff};

    // Acknowledge decision and following state per byte slot
    logic ack_now;
    ees_pkg::ees_state_e nxt_after;
    always_comb begin
        ack_now = 1'b0;
        nxt_after = ees_pkg::ST_IDLE;
        case (state_ff)
            ees_pkg::ST_SEL: begin
                ack_now = sel_hit;
                nxt_after = (sel_hit & ~sel_rd) ? ees_pkg::ST_AHI
                                                : ees_pkg::ST_IDLE;
            end
            ees_pkg::ST_AHI: begin
                ack_now = 1'b1;
                nxt_after = ees_pkg::ST_ALO;
            end
            ees_pkg::ST_ALO: begin
                ack_now = 1'b1;
                nxt_after = ees_pkg::ST_DATA;
            end
            ees_pkg::ST_DATA: begin
                ack_now = data_ok;
                nxt_after = ees_pkg::ST_DATA;
            end
            default: begin
                ack_now = 1'b0;
                nxt_after = ees_pkg::ST_IDLE;
            end
        endcase
    end

    // Two-stage pin synchronisers, then one stage for edge finding
    always_ff @(posedge i_clk) begin
        sync1_ff <= {i_write_protect_in, i_chip_addr_pin_hi,
                     i_chip_addr_pin_lo, i_sda_in, i_scl};
        sync2_ff <= sync1_ff;
        scl_d_ff <= scl_s;
        sda_d_ff <= sda_s;
    end

    // Protocol state; a write trigger parks the state in standby
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff <= ees_pkg::ST_IDLE;
        end else if (stop_det) begin
            state_ff <= ees_pkg::ST_IDLE;
        end else if (start_det) begin
            state_ff <= ees_pkg::ST_SEL;
        end else if (ack_close) begin
            state_ff <= after_ff;
        end
    end

    // Bit counter and shifter
    always_ff @(posedge i_clk) begin
        if (i_rst || start_det || stop_det) begin
            bit_cnt_ff <= 4'h0;
            in_ack_ff <= 1'b0;
        end else if (scl_rise && active && bit_cnt_ff < ees_pkg::BIT_ACK) begin
            shift_ff <= byte_in;
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end else if (ack_open) begin
            in_ack_ff <= 1'b1;
        end else if (ack_close) begin
            in_ack_ff <= 1'b0;
            bit_cnt_ff <= 4'h0;
        end
    end

    // Decision latched at the eighth bit, used through the ninth clock
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_dec_ff <= 1'b0;
            after_ff <= ees_pkg::ST_IDLE;
        end else if (byte_done) begin
            ack_dec_ff <= ack_now;
            after_ff <= nxt_after;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || start_det || stop_det || busy_ff) begin
            sda_oe_n_ff <= 1'b1;
        end else if (ack_open) begin
            sda_oe_n_ff <= ~ack_dec_ff;
        end else if (ack_close) begin
            sda_oe_n_ff <= 1'b1;
        end
        sda_out_ff <= 1'b0; // Open drain: only ever pulls low
    end

    // flag for tenth slot
    // Held through the tenth clock high: a stop can only come while it is up
    always_ff @(posedge i_clk) begin
        if (i_rst || start_det || stop_det) begin
            data_acked_ff <= 1'b0;
        end else if (ack_close && in_data && ack_dec_ff) begin
            data_acked_ff <= 1'b1;
        end else if (scl_fall) begin
            data_acked_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            top_bit_ff <= 1'b0;
            id_sel_ff <= 1'b0;
            addr_hi_ff <= 8'h00;
        end else if (byte_done && state_ff == ees_pkg::ST_SEL && sel_hit) begin
            top_bit_ff <= byte_in[ees_pkg::SEL_TOP_BIT];
            id_sel_ff <= (byte_in[7:4] == ees_pkg::TYPE_ID);
        end else if (byte_done && state_ff == ees_pkg::ST_AHI) begin
            addr_hi_ff <= byte_in;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            addr_lo_ff <= 8'h00;
            last_lo_ff <= 8'h00;
        end else if (byte_done && state_ff == ees_pkg::ST_ALO) begin
            addr_lo_ff <= byte_in;
        end else if (byte_done && in_data) begin
            addr_lo_ff <= addr_lo_ff + 8'h01;
            if (store) begin
                last_lo_ff <= addr_lo_ff;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || start_det) begin
            nbytes_ff <= 2'h0;
            lock_ok_ff <= 1'b0;
        end else if (byte_done && in_data && data_ok) begin
            nbytes_ff <= (nbytes_ff == 2'h2) ? 2'h2 : nbytes_ff + 2'h1;
            lock_ok_ff <= (nbytes_ff == 2'h0) &
                          byte_in[ees_pkg::LOCK_DATA_BIT];
        end
    end

    // Page buffer and received-byte mask; a fresh select clears the mask
    always_ff @(posedge i_clk) begin
        if (i_rst || start_det) begin
            mask_ff <= ees_pkg::MASK_RST;
        end else if (store) begin
            mask_ff[addr_lo_ff] <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (store) begin
            page_mem[addr_lo_ff] <= byte_in;
        end
    end

    // Group being drained during the write cycle
    wire [3:0] grp_mask = mask_ff[{grp_ff[5:0], 2'b00} +: ees_pkg::GRP_BYTES];
    wire drain_on = busy_ff & (grp_ff != ees_pkg::GRP_DONE);
    wire fifo_rdy = ~tail_vld_ff;
    wire push = drain_on & (grp_mask != 4'h0) & fifo_rdy;
    wire grp_step = drain_on & ((grp_mask == 4'h0) | fifo_rdy);
    wire pop = head_vld_ff & i_wr_ready;
    wire tw_done = (tw_cnt_ff == TW_LAST);
    wire fifo_empty = ~head_vld_ff & ~tail_vld_ff;
    wire cyc_end = busy_ff & tw_done & ~drain_on & fifo_empty;
    wire [31:0] grp_data;
    ees_pkg::ees_wr_s in_entry;

    genvar gi;
    generate
        for (gi = 0; gi < ees_pkg::GRP_BYTES; gi++) begin : g_grp
            assign grp_data[gi*8 +: 8] = page_mem[{grp_ff[5:0], 2'(gi)}];
        end
    endgenerate

    assign in_entry.id_page = id_sel_ff;
    assign in_entry.grp_addr = {page_hi, grp_ff[5:0]};
    assign in_entry.mask = grp_mask;
    assign in_entry.data = grp_data;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_ff <= 1'b0;
            tw_cnt_ff <= 20'h00000;
            grp_ff <= 7'h00;
        end else if (wr_trig) begin
            busy_ff <= 1'b1;
            tw_cnt_ff <= 20'h00000;
            grp_ff <= 7'h00;
        end else if (cyc_end) begin
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            tw_cnt_ff <= tw_done ? tw_cnt_ff : tw_cnt_ff + 20'h00001;
            grp_ff <= grp_step ? grp_ff + 7'h01 : grp_ff;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            addr_cnt_ff <= ees_pkg::ADDR_RST;
            lock_pend_ff <= 1'b0;
            lock_ff <= 1'b0;
        end else begin
            if (wr_trig) begin
                lock_pend_ff <= lock_cmd & lock_ok_ff & (nbytes_ff == 2'h1);
            end
            if (cyc_end) begin
                addr_cnt_ff <= {page_hi, last_lo_ff + 8'h01};
            end
            lock_ff <= lock_ff | i_id_locked_nv | (cyc_end & lock_pend_ff);
        end
    end

    // Two-entry buffer; a stalled array port holds the drain
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            head_vld_ff <= 1'b0;
            tail_vld_ff <= 1'b0;
        end else begin
            if (!head_vld_ff || pop) begin
                head_vld_ff <= tail_vld_ff | push;
                head_ff <= tail_vld_ff ? tail_ff : in_entry;
            end
            if (tail_vld_ff && (!head_vld_ff || pop)) begin
                tail_vld_ff <= 1'b0;
            end else if (push && head_vld_ff && !pop) begin
                tail_vld_ff <= 1'b1;
                tail_ff <= in_entry;
            end
        end
    end

    // Outputs straight from their flops
    assign o_sda_out = sda_out_ff;
    assign o_sda_oe_n = sda_oe_n_ff;
    assign o_wr_valid = head_vld_ff;
    assign o_wr_entry = head_ff;
    assign o_busy = busy_ff;
    assign o_id_locked = lock_ff;
    assign o_addr_cnt = addr_cnt_ff;

    // Checks on the protocol engine
    chk_start_select: assert property (
        @(posedge i_clk) disable iff (i_rst)
        start_det |=> state_ff == ees_pkg::ST_SEL && bit_cnt_ff == 4'h0)
        else $error("start did not open select byte");

    chk_stop_standby: assert property (
        @(posedge i_clk) disable iff (i_rst)
        stop_det |=> state_ff == ees_pkg::ST_IDLE && sda_oe_n_ff)
        else $error("stop did not return to standby");

    chk_sample_rise: assert property (
        @(posedge i_clk) disable iff (i_rst)
        scl_rise && active && bit_cnt_ff < ees_pkg::BIT_LAST && !stop_det
        && !start_det |=> shift_ff[0] == $past(sda_s))
        else $error("bit not sampled on rising clock");

    chk_ack_drive: assert property (
        @(posedge i_clk) disable iff (i_rst)
        ack_open && ack_dec_ff && !start_det && !stop_det
        |=> !sda_oe_n_ff ##1 (!sda_oe_n_ff || $past(ack_close)))
        else $error("acknowledge not driven in ninth clock");

    chk_chip_miss: assert property (
        @(posedge i_clk) disable iff (i_rst)
        byte_done && state_ff == ees_pkg::ST_SEL && byte_in[3:2] != chip_s
        |=> !ack_dec_ff && after_ff == ees_pkg::ST_IDLE)
        else $error("mismatched chip address acknowledged");

    chk_busy_quiet: assert property (
        @(posedge i_clk) disable iff (i_rst)
        busy_ff |=> sda_oe_n_ff && state_ff == ees_pkg::ST_IDLE)
        else $error("bus driven during write cycle");

    chk_protect_nack: assert property (
        @(posedge i_clk) disable iff (i_rst)
        byte_done && in_data && wp_s |=> !ack_dec_ff && !$past(store))
        else $error("protected data byte accepted");

    chk_addr_ack: assert property (
        @(posedge i_clk) disable iff (i_rst)
        byte_done && (state_ff == ees_pkg::ST_AHI ||
        state_ff == ees_pkg::ST_ALO) |=> ack_dec_ff)
        else $error("address byte not acknowledged");

    chk_write_slot: assert property (
        @(posedge i_clk) disable iff (i_rst)
        stop_det && !(in_data && data_acked_ff) && !busy_ff |=> !busy_ff)
        else $error("write started outside tenth slot");

    chk_page_wrap: assert property (
        @(posedge i_clk) disable iff (i_rst)
        byte_done && in_data && addr_lo_ff == 8'hFF && !stop_det
        |=> addr_lo_ff == 8'h00)
        else $error("page counter did not wrap");

    chk_locked_nack: assert property (
        @(posedge i_clk) disable iff (i_rst)
        byte_done && in_data && id_sel_ff && lock_ff |=> !ack_dec_ff)
        else $error("locked page byte acknowledged");

    chk_cycle_min: assert property (
        @(posedge i_clk) disable iff (i_rst)
        busy_ff && tw_cnt_ff != TW_LAST |=> busy_ff)
        else $error("write cycle ended early");

    chk_addr_next: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $fell(busy_ff) |-> addr_cnt_ff[7:0] == last_lo_ff + 8'h01)
        else $error("address counter not past last byte");

endmodule

// >>> inc/ees_pkg.sv
// Purpose: Shared constants and types for the two-wire memory slave
// Assumes: 100 MHz system clock, 17-bit byte address, 256-byte pages
// Notes: Timing counts follow from the write time and the system clock
package ees_pkg;

    // Select byte layout
    localparam logic [3:0] TYPE_MEM = 4'hA;
    localparam logic [3:0] TYPE_ID = 4'hB;
    localparam int SEL_TYPE_LSB = 4;
    localparam int SEL_CHIP_LSB = 2;
    localparam int SEL_TOP_BIT = 1;
    localparam int SEL_RW_BIT = 0;

    // Address and page geometry
    localparam int ADDR_W = 17;
    localparam int PAGE_BYTES = 256;
    localparam int GRP_BYTES = 4;
    localparam int GRP_W = 15;
    localparam logic [6:0] GRP_DONE = 7'h40;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;

    // Lock command fields: bit 2 of the high address byte, data bit 1
    localparam int LOCK_SEL_BIT = 2;
    localparam int LOCK_DATA_BIT = 1;

    // Reset values
    localparam logic [16:0] ADDR_RST = 17'h00000;
    localparam logic [255:0] MASK_RST = '0;

    // Internal write time and its cycle count
    localparam int TW_MS = 5;
    localparam int CLK_MHZ = 100;
    localparam int TW_CYCLES = TW_MS * 1000 * CLK_MHZ;

    // Bus protocol states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEL,
        ST_AHI,
        ST_ALO,
        ST_DATA
    } ees_state_e;

    // One group-of-four rewrite toward the array
    typedef struct packed {
        logic id_page;
        logic [GRP_W-1:0] grp_addr;
        logic [3:0] mask;
        logic [31:0] data;
    } ees_wr_s;

endpackage

// >>> test/ees_master_mdl.sv
// Purpose: Behavioural two-wire bus master driving the slave under test
// Assumes: Bus clock period of 16 system clocks (160 ns)
// Notes: Data is changed 60 ns into the low phase, away from edges
`timescale 1ns/1ps
module ees_master_mdl (
    // Clock and observed wire
    input wire logic i_clk,
    input wire logic i_sda,
    // Driven bus pins
    output logic o_scl,
    output logic o_sda_low
);
    // Idle bus: clock parked high, data released to the pull-up
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // Steps are launched just after a system clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic pin(input logic low, input logic clk, input int n);
        o_sda_low = low;
        o_scl = clk;
        tick(n);
    endtask

    task automatic start();
        tick(6);
        pin(1'b0, 1'b0, 2);
        pin(1'b0, 1'b1, 8);
        pin(1'b1, 1'b1, 8);
        pin(1'b1, 1'b0, 0);
    endtask

    task automatic stop();
        tick(6);
        pin(1'b1, 1'b0, 2);
        pin(1'b1, 1'b1, 8);
        pin(1'b0, 1'b1, 8);
    endtask

    // msb first, change while low, release for ack
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            tick(6);
            pin(~b[i], 1'b0, 2);
            pin(~b[i], 1'b1, 8);
            pin(~b[i], 1'b0, 0);
        end
        tick(6);
        pin(1'b0, 1'b0, 2);
        pin(1'b0, 1'b1, 4);
        ack = (i_sda === 1'b0);
        pin(1'b0, 1'b1, 4);
        pin(1'b0, 1'b0, 0);
    endtask
endmodule

// >>> test/ees_slave_tb.sv
// Purpose: Self-checking bench for the two-wire memory slave write path
// Assumes: Chip pins strapped to 2'b10, short write cycle parameter
// Notes: Array side stalls ready to fill the two-entry buffer
`timescale 1ns/1ps
module ees_slave_tb;
    localparam int WR_N = 400;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic wp = 1'b0;
    logic rdy = 1'b1;
    logic scl, sda_low, sda_out, sda_oe_n, wire_sda, a;
    logic wr_valid, busy, id_locked;
    logic [16:0] addr_cnt;
    ees_pkg::ees_wr_s wr_entry;
    ees_pkg::ees_wr_s got_q[$];
    int err_count = 0;
    int check_count = 0;

    always #5 i_clk = ~i_clk;
    // Open-drain wire with pull-up
    assign wire_sda = (sda_oe_n ? 1'b1 : sda_out) & ~sda_low;

    ees_master_mdl m (.i_clk(i_clk), .i_sda(wire_sda), .o_scl(scl),
        .o_sda_low(sda_low));
    ees_slave #(.WR_CYCLES(WR_N)) DUT (.i_clk(i_clk), .i_rst(i_rst),
        .i_scl(scl), .i_sda_in(wire_sda), .o_sda_out(sda_out),
        .o_sda_oe_n(sda_oe_n), .i_chip_addr_pin_lo(1'b0),
        .i_chip_addr_pin_hi(1'b1), .i_write_protect_in(wp),
        .i_id_locked_nv(1'b0), .o_wr_valid(wr_valid),
        .o_wr_entry(wr_entry), .i_wr_ready(rdy), .o_busy(busy),
        .o_id_locked(id_locked), .o_addr_cnt(addr_cnt));

    // Array side: record every accepted group rewrite
    always @(posedge i_clk) begin
        if (wr_valid === 1'b1 && rdy === 1'b1) begin
            got_q.push_back(wr_entry);
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic exp_ack);
        m.send_byte(b, a);
        chk(a, exp_ack);
    endtask

    // Bounded wait until busy reaches the given level
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl && n < lim) begin
            @(posedge i_clk);
            #1;
            n++;
        end
    endtask

    task automatic ent(input int i, input logic [19:0] hdr,
                       input logic [31:0] d, input logic [31:0] dm);
        ees_pkg::ees_wr_s e;
        e = got_q[i];
        chk({e.id_page, e.grp_addr, e.mask}, hdr);
        chk(e.data & dm, d);
    endtask

    task automatic t_byte();
        got_q.delete();
        m.start();
        send(8'hA8, 1'b1);
        send(8'h12, 1'b1);
        send(8'h35, 1'b1);
        send(8'hA5, 1'b1);
        m.stop();
        wait_busy(1'b1, 20);
        chk(busy, 1'b1);
        m.start();
        send(8'hA8, 1'b0);
        m.stop();
        wait_busy(1'b0, 2000);
        chk(addr_cnt, 17'h01236);
        chk(got_q.size(), 1);
        ent(0, {1'b0, 15'h048D, 4'h2}, 32'h0000A500, 32'h0000FF00);
        m.start();
        send(8'hA8, 1'b1);
        m.stop();
        wait_busy(1'b1, 40);
        chk(busy, 1'b0);
        $display("test byte write done");
    endtask

    task automatic t_page();
        got_q.delete();
        rdy = 1'b0;
        m.start();
        send(8'hAA, 1'b1);
        send(8'h23, 1'b1);
        send(8'hFE, 1'b1);
        for (int i = 0; i < 7; i++) begin
            send(8'h10 + 8'(i), 1'b1);
        end
        m.stop();
        wait_busy(1'b1, 20);
        m.tick(WR_N + 100);
        chk({wr_valid, busy}, 2'b11);
        rdy = 1'b1;
        wait_busy(1'b0, 2000);
        chk(got_q.size(), 3);
        ent(0, {1'b0, 15'h48C0, 4'hF}, 32'h15141312, 32'hFFFFFFFF);
        ent(1, {1'b0, 15'h48C1, 4'h1}, 32'h00000016, 32'h000000FF);
        ent(2, {1'b0, 15'h48FF, 4'hC}, 32'h11100000, 32'hFFFF0000);
        chk(addr_cnt, 17'h12305);
        $display("test page write done");
    endtask

    task automatic t_refuse();
        logic [7:0] sel[3] = '{8'hA4, 8'hC8, 8'hAC};
        foreach (sel[i]) begin
            m.start();
            send(sel[i], 1'b0);
            send(8'h00, 1'b0);
            m.stop();
        end
        m.start();
        send(8'hA9, 1'b1);
        m.start();
        send(8'hA8, 1'b1);
        send(8'h12, 1'b1);
        m.stop();
        wp = 1'b1;
        m.start();
        send(8'hA8, 1'b1);
        send(8'h00, 1'b1);
        send(8'h00, 1'b1);
        send(8'h55, 1'b0);
        m.stop();
        wp = 1'b0;
        wait_busy(1'b1, 40);
        chk(busy, 1'b0);
        $display("test refusals done");
    endtask

    task automatic t_id();
        got_q.delete();
        m.start();
        send(8'hB8, 1'b1);
        send(8'h00, 1'b1);
        send(8'h07, 1'b1);
        send(8'h5A, 1'b1);
        m.stop();
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 2000);
        ent(0, {1'b1, 15'h0001, 4'h8}, 32'h5A000000, 32'hFF000000);
        chk(addr_cnt, 17'h00008);
        m.start();
        send(8'hB8, 1'b1);
        send(8'h04, 1'b1);
        send(8'h00, 1'b1);
        send(8'h02, 1'b1);
        m.stop();
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 2000);
        chk({id_locked, 8'(got_q.size())}, {1'b1, 8'h01});
        m.start();
        send(8'hB8, 1'b1);
        send(8'h00, 1'b1);
        send(8'h00, 1'b1);
        send(8'h77, 1'b0);
        m.stop();
        $display("test id page done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog: the whole run needs roughly 8000 clocks
    initial begin
        #500us;
        err_count++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        chk({sda_oe_n, wr_valid, busy, addr_cnt}, {3'b100, 17'h0});
        m.tick(6);
        t_byte();
        t_page();
        t_refuse();
        t_id();
        end_sim();
    end
endmodule
